/* src/switch_sync.sv */
// Switch synchroniser with antivalence check, cascade link and a
// companion error-output combiner, all behind an APB register port.
// Assumes all pin inputs are synchronous to pclk and that a cascade
// peer loop returns through a one-logic-cycle marker register.
//
// Notes on behaviour
// - With cascade enabled the unit drives a cascade output too.
// - Chained units release more than six inputs in one logic cycle.
// - A cascade-started timer is shortened by one logic cycle for the marker delay.
// - Cascade input rising edge starts timer from previous cycle time.
// - At expiry outputs copy inputs, whatever the check, and then hold.
// - Antivalence check runs at every expiry when enabled.
// - Any used pair not one-low-one-high raises the antivalence error.
// - Error clears only after a later clean synchronisation or when run goes low.
// - Stop-to-run loads outputs and checks at once, no hold wait.
// - Combiner takes one or two error inputs.
// - Combiner handles one to six data inputs and outputs.
// - Each combiner output has its own forced high or low value.
// - Any configured error high forces used outputs; otherwise they follow inputs.
// - Hold is 10 ms to 10 s in 10 ms steps.
// - Without cascade any used input change starts the timer.
// - An inverted input is evaluated and output complemented.
// - One unit handles one to six inputs in three pairs.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module switch_sync #(
  parameter logic [31:0] LOGIC_CYC = sync_pkg::LOGIC_CYC,
  parameter logic [31:0] TEN_MS_CYC = sync_pkg::TEN_MS_CYC
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller run state, high in Run.
  input wire logic run,
  // Synchroniser link.
  input wire logic [5:0] sync_in,
  input wire logic cascade_in,
  output logic [5:0] sync_out,
  output logic antival_err,
  output logic cascade_out,
  // Error combiner link.
  input wire logic [5:0] comb_in,
  input wire logic comb_err1,
  input wire logic comb_err2,
  output logic [5:0] comb_out
);
  ////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [31:0] tick_cnt;
    logic run_q;
    logic [5:0] samp;
    logic casc_in;
    logic [5:0] out;
    logic err;
    logic casc_out;
    logic casc_en;
    logic anti_en;
    logic [2:0] num;
    logic [5:0] inv;
    logic two_err;
    logic [2:0] cnum;
    logic [9:0] hold;
    logic [5:0] force_v;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;
  state_t q, d;

  logic tick;
  logic first;
  logic load_now;
  logic changed;
  logic start_nc;
  logic start_c;
  logic tmr_clear;
  logic tmr_done;
  logic tmr_run;
  logic tmr_exp;
  logic [5:0] mask;
  logic [5:0] vals;
  logic [31:0] target;
  logic [9:0] hold_w;
  logic wr_now;

  ////////////////////////////////////////////////////////////////////
  // Logic-cycle decode and synchroniser events.

  // A logic cycle ends on tick; all synchroniser link behaviour happens only then.
  assign tick = (q.tick_cnt == LOGIC_CYC - 32'h1);
  assign mask = sync_pkg::used_mask(q.num);
  assign vals = (sync_in ^ q.inv) & mask;
  assign changed = (vals != q.samp);
  assign first = tick && run && !q.run_q;
  // Expiry is only looked at on a tick, so outputs move at boundaries.
  assign tmr_done = tick && run && tmr_exp;
  assign load_now = first || tmr_done;
  // Stopping or a fresh start drops any hold in progress.
  assign tmr_clear = tick && (!run || first);
  // A change while holding is absorbed by the hold already running.
  assign start_nc = tick && run && !first && !q.casc_en && changed
                    && !tmr_run;
  assign start_c = tick && run && !first && q.casc_en && cascade_in
                   && !q.casc_in && !tmr_run;
  // The product stays under 2**32 for the largest hold of 10 s.
  assign target = 32'(q.hold) * TEN_MS_CYC;
  assign hold_w = pwdata[9:0];
  assign wr_now = psel && penable && pwrite && q.pready && !q.pslverr;

  ////////////////////////////////////////////////////////////////////
  // Hold timer.
  // A cascade start is counted from the previous logic cycle, which
  // also makes up for the cycle lost in the marker loop.
  hold_timer u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .start(start_nc || start_c),
    .clear(tmr_clear),
    .done(tmr_done),
    .preload(start_c ? LOGIC_CYC : 32'h0),
    .target(target),
    .running(tmr_run),
    .expired(tmr_exp)
  );

  ////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    d = q;
    d.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;
    if (tick) begin
      d.run_q = run;
      d.casc_in = cascade_in;
      d.samp = vals;
      // Peers see this through the marker one logic cycle later.
      d.casc_out = run && q.casc_en && changed && !first;
      if (!run) begin
        d.out = 6'h00;
        d.err = 1'b0;
      end else if (load_now) begin
        d.out = vals;
        // The data path above ignores the check result on purpose.
        d.err = q.anti_en && sync_pkg::pair_fault(vals, mask);
      end
    end
    // APB setup phase: answer in the first access cycle.
    d.pready = psel && !penable;
    d.pslverr = 1'b0;
    if (psel && !penable) begin
      d.prdata = 32'h0;
      case (paddr)
        sync_pkg::CTRL_OFF: begin
          d.prdata[sync_pkg::CASC_BIT] = q.casc_en;
          d.prdata[sync_pkg::ANTI_BIT] = q.anti_en;
          d.prdata[sync_pkg::NUM_LSB +: 3] = q.num;
          d.prdata[sync_pkg::INV_LSB +: 6] = q.inv;
          d.prdata[sync_pkg::TWO_ERR_BIT] = q.two_err;
          d.prdata[sync_pkg::CNUM_LSB +: 3] = q.cnum;
        end
        sync_pkg::HOLD_OFF: d.prdata[9:0] = q.hold;
        sync_pkg::FORCE_OFF: d.prdata[5:0] = q.force_v;
        sync_pkg::STATUS_OFF: begin
          d.prdata[5:0] = q.out;
          d.prdata[sync_pkg::ST_ERR_BIT] = q.err;
          d.prdata[sync_pkg::ST_RUN_BIT] = tmr_run;
          d.prdata[sync_pkg::ST_CASC_BIT] = q.casc_out;
          d.prdata[sync_pkg::ST_COMB_LSB +: 6] = comb_out;
        end
        default: d.pslverr = 1'b1;
      endcase
    end
    // Writes land at the access edge that also samples pready.
    if (wr_now) begin
      case (paddr)
        sync_pkg::CTRL_OFF: begin
          d.casc_en = pwdata[sync_pkg::CASC_BIT];
          d.anti_en = pwdata[sync_pkg::ANTI_BIT];
          d.num = pwdata[sync_pkg::NUM_LSB +: 3];
          d.inv = pwdata[sync_pkg::INV_LSB +: 6];
          d.two_err = pwdata[sync_pkg::TWO_ERR_BIT];
          d.cnum = pwdata[sync_pkg::CNUM_LSB +: 3];
        end
        sync_pkg::HOLD_OFF: begin
          // Out-of-range holds are clamped rather than refused.
          if (hold_w < sync_pkg::HOLD_MIN) begin
            d.hold = sync_pkg::HOLD_MIN;
          end else if (hold_w > sync_pkg::HOLD_MAX) begin
            d.hold = sync_pkg::HOLD_MAX;
          end else begin
            d.hold = hold_w;
          end
        end
        sync_pkg::FORCE_OFF: d.force_v = pwdata[5:0];
        default: d.hold = q.hold;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register; a low ce freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{tick_cnt: 32'h0, run_q: 1'b0, samp: 6'h00,
             casc_in: 1'b0, out: 6'h00, err: 1'b0, casc_out: 1'b0,
             casc_en: 1'b0, anti_en: 1'b0, num: sync_pkg::NUM_RST,
             inv: 6'h00, two_err: 1'b0, cnum: sync_pkg::NUM_RST,
             hold: sync_pkg::HOLD_RST, force_v: 6'h00,
             prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops.
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sync_out = q.out;
  assign antival_err = q.err;
  assign cascade_out = q.casc_out;

  ////////////////////////////////////////////////////////////////////
  // Error combiner, registered inside its own module.
  error_combiner u_comb (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .two_err(q.two_err),
    .num(q.cnum),
    .force_val(q.force_v),
    .data_in(comb_in),
    .err1(comb_err1),
    .err2(comb_err2),
    .data_out(comb_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (ce && psel && !penable |=> pready) else $error("pready late");
  out_hold_a: assert property (!(ce && tick) |=> $stable(sync_out)) else $error("outputs moved off tick");
  expiry_copy_a: assert property (ce && run && tmr_done |=> sync_out == $past(vals)) else $error("expiry load wrong");
  start_load_a: assert property (ce && first |=> sync_out == $past(vals) && !tmr_run) else $error("startup load wrong");
  anti_set_a: assert property (ce && load_now && q.anti_en && sync_pkg::pair_fault(vals, mask) |=> antival_err) else $error("error not raised");
  err_clear_a: assert property ($fell(antival_err) |-> $past(ce && (load_now || !run))) else $error("error cleared early");
  nc_start_a: assert property (ce && start_nc |=> tmr_run) else $error("change did not start hold");
  casc_start_a: assert property (ce && start_c |=> tmr_run) else $error("cascade start lost");
  casc_out_a: assert property (ce && tick && run && !first && q.casc_en && changed |=> cascade_out) else $error("cascade out missing");

  sync_done_c: cover property (ce && tmr_done);
  anti_err_c: cover property (ce && load_now && q.anti_en && sync_pkg::pair_fault(vals, mask));
  casc_start_c: cover property (ce && start_c);
  comb_force_c: cover property (ce && comb_err2 && q.two_err);
endmodule
`default_nettype wire

/* src/sync_pkg.sv */
// Shared constants for the switch synchroniser and its error combiner.
// Assumes a 250 MHz pclk and an APB register port with 32-bit data.
package sync_pkg;
  // Register byte offsets.
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] HOLD_OFF = 12'h004;
  localparam logic [11:0] FORCE_OFF = 12'h008;
  localparam logic [11:0] STATUS_OFF = 12'h00C;
  // Control field positions.
  localparam int CASC_BIT = 0;
  localparam int ANTI_BIT = 1;
  localparam int NUM_LSB = 2;
  localparam int INV_LSB = 5;
  localparam int TWO_ERR_BIT = 11;
  localparam int CNUM_LSB = 12;
  // Status field positions.
  localparam int ST_ERR_BIT = 6;
  localparam int ST_RUN_BIT = 7;
  localparam int ST_CASC_BIT = 8;
  localparam int ST_COMB_LSB = 9;
  // Reset values and hold limits, hold counted in 10 ms steps.
  localparam logic [2:0] NUM_RST = 3'h6;
  localparam logic [9:0] HOLD_RST = 10'h001;
  localparam logic [9:0] HOLD_MIN = 10'h001;
  localparam logic [9:0] HOLD_MAX = 10'h3E8;
  // Timing.
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned TEN_MS_NS = 10000000;
  localparam int unsigned TEN_MS_CYC = TEN_MS_NS / CLK_NS;
  localparam int unsigned LOGIC_NS = 4000000;
  localparam int unsigned LOGIC_CYC = LOGIC_NS / CLK_NS;

  // Mask of the signals in use for a configured count of 1 to 6.
  function automatic logic [5:0] used_mask(input logic [2:0] n);
    case (n)
      3'h1: used_mask = 6'h01;
      3'h2: used_mask = 6'h03;
      3'h3: used_mask = 6'h07;
      3'h4: used_mask = 6'h0F;
      3'h5: used_mask = 6'h1F;
      default: used_mask = 6'h3F;
    endcase
  endfunction

  // High when any complete used pair is not one low and one high.
  function automatic logic pair_fault(input logic [5:0] v,
                                      input logic [5:0] m);
    pair_fault = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (m[2*p+1] && (v[2*p] == v[2*p+1])) begin
        pair_fault = 1'b1;
      end
    end
  endfunction
endpackage

/* src/hold_timer.sv */
// Hold timer of the switch synchroniser, counted in pclk cycles.
// Assumes the caller samples expiry only on logic-cycle ticks.
`timescale 1ns/10ps
`default_nettype none
module hold_timer (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control.
  input wire logic start,
  input wire logic clear,
  input wire logic done,
  input wire logic [31:0] preload,
  input wire logic [31:0] target,
  // State.
  output logic running,
  output logic expired
);
  typedef enum logic {T_IDLE, T_HOLD} tstate_t;
  typedef struct packed {
    tstate_t st;
    logic [31:0] elapsed;
  } state_t;
  state_t q, d;

  // Elapsed time saturates so a stalled consumer never sees a wrap.
  always_comb begin
    d = q;
    if (clear) begin
      d.st = T_IDLE;
      d.elapsed = 32'h0;
    end else begin
      case (q.st)
        T_IDLE: if (start) begin
          d.st = T_HOLD;
          d.elapsed = preload;
        end
        T_HOLD: if (done) begin
          d.st = T_IDLE;
        end else if (q.elapsed != 32'hFFFFFFFF) begin
          d.elapsed = q.elapsed + 32'h1;
        end
        default: d.st = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: T_IDLE, elapsed: 32'h0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign running = (q.st == T_HOLD);
  assign expired = running && (q.elapsed >= target);
endmodule
`default_nettype wire

/* src/error_combiner.sv */
// Error-output combiner: forces configured values while an error is high.
// Assumes data and error inputs are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module error_combiner (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration.
  input wire logic two_err,
  input wire logic [2:0] num,
  input wire logic [5:0] force_val,
  // Data.
  input wire logic [5:0] data_in,
  input wire logic err1,
  input wire logic err2,
  output logic [5:0] data_out
);
  typedef struct packed {
    logic [5:0] out;
  } state_t;
  state_t q, d;
  logic err;
  logic [5:0] mask;
  logic [5:0] nxt;

  // The second error input only counts when it is configured.
  assign err = err1 || (two_err && err2);
  assign mask = sync_pkg::used_mask(num);

  // Unused outputs are held low so they never look like live data.
  for (genvar i = 0; i < 6; i++) begin : g_out
    assign nxt[i] = mask[i] && (err ? force_val[i] : data_in[i]);
  end

  always_comb begin
    d = q;
    d.out = nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{out: 6'h00};
    end else if (ce) begin
      q <= d;
    end
  end
  assign data_out = q.out;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  comb_force_a: assert property (ce && err |=> data_out == $past(force_val & mask)) else $error("forced value missing");
  comb_pass_a: assert property (ce && !err |=> data_out == $past(data_in & mask)) else $error("input not passed");
endmodule
`default_nettype wire

/* sim/cascade_marker.sv */
// Partner model: the marker register that returns the ORed cascade outputs.
// Assumes ce stays high, so its own tick count follows the unit's count.
`timescale 1ns/10ps
`default_nettype none
module cascade_marker #(
  parameter int LOGIC_CYC = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Cascade loop.
  input wire logic casc_outs,
  output logic casc_ret
);
  int cnt_q;

  //////////////////////////////////////////////////////////////////////////
  // A capture in mid-cycle keeps clear of the unit's tick edge, so the
  // returned level never races the edge at which the unit samples it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
      casc_ret <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == LOGIC_CYC - 1) ? 0 : cnt_q + 1;
      if (cnt_q == LOGIC_CYC / 2) begin
        casc_ret <= casc_outs;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb_switch_sync.sv */
// Self-checking bench for the switch synchroniser and error combiner.
// Assumes the marker model closes the cascade loop of a single unit.
`timescale 1ns/10ps
`default_nettype none
module tb_switch_sync;
  localparam int LC = 8;
  localparam int TM = 4;
  typedef struct packed {
    logic two;
    logic [2:0] cnum;
    logic [5:0] frc;
    logic [5:0] din;
    logic e1;
    logic e2;
    logic [5:0] want;
  } row_t;
  logic pclk, presetn, ce, psel, penable, pwrite, run, cascade_in;
  logic comb_err1, comb_err2, pready, pslverr, antival_err, cascade_out;
  logic last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] sync_in, sync_out, comb_in, comb_out;
  int n_fail, n_compared, k;
  row_t rows [6];

  switch_sync #(.LOGIC_CYC(LC), .TEN_MS_CYC(TM)) dut_u (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run(run), .sync_in(sync_in),
    .cascade_in(cascade_in), .sync_out(sync_out),
    .antival_err(antival_err), .cascade_out(cascade_out),
    .comb_in(comb_in), .comb_err1(comb_err1), .comb_err2(comb_err2),
    .comb_out(comb_out));
  cascade_marker #(.LOGIC_CYC(LC)) mark_u (.clk(pclk), .rst_n(presetn),
    .casc_outs(cascade_out), .casc_ret(cascade_in));

  //////////////////////////////////////////////////////////////////////////
  // One comparison; four-state equality so an unknown never matches.
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, want);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits a bounded time for the synchroniser outputs to reach a value.
  task automatic wait_out(input logic [5:0] want, input int n);
    int m;
    m = 0;
    @(negedge pclk);
    while (sync_out !== want && m < n) begin
      @(negedge pclk);
      m++;
    end
    check({26'h0, sync_out}, {26'h0, want});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // A hang costs a mismatch; the whole run needs under 400 cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  // Main sequence: reset, combiner table, then synchroniser cases.
  initial begin
    {presetn, ce, psel, penable, pwrite, run, comb_err1, comb_err2} = '0;
    {paddr, pwdata, comb_in} = '0;
    sync_in = 6'h15;
    n_fail = 0;
    n_compared = 0;
    rows[0] = '{1'b0, 3'h6, 6'h2A, 6'h15, 1'b0, 1'b0, 6'h15};
    rows[1] = '{1'b0, 3'h6, 6'h2A, 6'h15, 1'b1, 1'b0, 6'h2A};
    rows[2] = '{1'b0, 3'h6, 6'h2A, 6'h15, 1'b0, 1'b1, 6'h15};
    rows[3] = '{1'b1, 3'h6, 6'h2A, 6'h15, 1'b0, 1'b1, 6'h2A};
    rows[4] = '{1'b1, 3'h3, 6'h00, 6'h3F, 1'b0, 1'b0, 6'h07};
    rows[5] = '{1'b0, 3'h1, 6'h3F, 6'h00, 1'b1, 1'b0, 6'h01};
    ce = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({antival_err, cascade_out, sync_out, comb_out}, 32'h0);
    apb(1'b0, sync_pkg::CTRL_OFF, 32'h0, q);
    check(q, 32'h0000_6018);
    apb(1'b0, 12'h010, 32'h0, q);
    check({31'h0, last_err}, 32'h1);
    apb(1'b1, sync_pkg::HOLD_OFF, 32'h0, q);
    apb(1'b0, sync_pkg::HOLD_OFF, 32'h0, q);
    check(q, 32'h1);
    apb(1'b1, sync_pkg::HOLD_OFF, 32'h3FF, q);
    apb(1'b0, sync_pkg::HOLD_OFF, 32'h0, q);
    check(q, 32'h3E8);
    // Combiner rows: configuration, inputs, then the expected outputs.
    foreach (rows[i]) begin
      apb(1'b1, sync_pkg::CTRL_OFF, {17'h0, rows[i].cnum, rows[i].two,
          11'h018}, q);
      apb(1'b1, sync_pkg::FORCE_OFF, {26'h0, rows[i].frc}, q);
      comb_in <= rows[i].din;
      comb_err1 <= rows[i].e1;
      comb_err2 <= rows[i].e2;
      repeat (3) @(negedge pclk);
      check({26'h0, comb_out}, {26'h0, rows[i].want});
    end
    // Hold of 40 ms is 16 cycles, two ticks of 8.
    apb(1'b1, sync_pkg::HOLD_OFF, 32'h4, q);
    apb(1'b1, sync_pkg::CTRL_OFF, 32'h0000_601A, q);
    run <= 1'b1;
    wait_out(6'h15, LC + 2);
    check({31'h0, antival_err}, 32'h0);
    // Pair 1 equal: outputs freeze for the hold, then load and flag.
    sync_in <= 6'h17;
    repeat (LC) @(negedge pclk);
    check({26'h0, sync_out}, 32'h15);
    wait_out(6'h17, 4 * LC);
    check({31'h0, antival_err}, 32'h1);
    sync_in <= 6'h25;
    wait_out(6'h25, 4 * LC);
    check({31'h0, antival_err}, 32'h0);
    // Invert the first input: 25 is seen as 24, pair 1 now equal.
    apb(1'b1, sync_pkg::CTRL_OFF, 32'h0000_603A, q);
    wait_out(6'h24, 4 * LC);
    check({31'h0, antival_err}, 32'h1);
    // Three inputs: the lone third input is not checked, unused ignored.
    apb(1'b1, sync_pkg::CTRL_OFF, 32'h0000_600E, q);
    wait_out(6'h05, 4 * LC);
    check({31'h0, antival_err}, 32'h0);
    sync_in <= 6'h05;
    repeat (4 * LC) @(negedge pclk);
    check({26'h0, sync_out}, 32'h05);
    // Stop clears, stop-to-run loads at once without the hold.
    run <= 1'b0;
    wait_out(6'h00, LC + 2);
    sync_in <= 6'h03;
    run <= 1'b1;
    wait_out(6'h03, LC + 2);
    check({31'h0, antival_err}, 32'h1);
    // Cascade: one input, the loop returns through the marker.
    apb(1'b1, sync_pkg::HOLD_OFF, 32'h4, q);
    apb(1'b1, sync_pkg::CTRL_OFF, 32'h0000_6005, q);
    sync_in <= 6'h02;
    k = 0;
    while (cascade_out !== 1'b1 && k < 3 * LC) begin
      @(negedge pclk);
      k++;
    end
    check({31'h0, cascade_out}, 32'h1);
    check({26'h0, sync_out}, 32'h03);
    wait_out(6'h00, 6 * LC);
    check({31'h0, antival_err}, 32'h0);
    // Status shows the cleared outputs and the forced combiner outputs.
    apb(1'b0, sync_pkg::STATUS_OFF, 32'h0, q);
    check(q, 32'h0000_7E00);
    finish_test();
  end
endmodule
`default_nettype wire
